/* File: rtl/wdt_pkg.sv */
/*
 Shared constants and types for the watchdog timer block.
 Assumes a single clock domain; every input is synchronous to it.
*/
package wdt_pkg;

   // =====================================================================
   // enable configuration field encodings
   localparam logic [1:0] CFG_OFF = 2'h0;
   localparam logic [1:0] CFG_RUN_IDLE = 2'h1;
   localparam logic [1:0] CFG_SOFTWARE = 2'h2;
   localparam logic [1:0] CFG_ALWAYS = 2'h3;

   // =====================================================================
   // prescaler: one tick every 32 clocks (PRESCALE_LAST + 1)
   localparam int PRESCALE_WIDTH = 5;
   localparam logic [PRESCALE_WIDTH-1:0] PRESCALE_LAST = 5'h1f;
   localparam logic [PRESCALE_WIDTH-1:0] PRESCALE_RESET = 5'h00;

   // =====================================================================
   // main counter and postscaler
   localparam int COUNT_WIDTH = 8;
   localparam logic [COUNT_WIDTH-1:0] COUNT_LAST = 8'hff;
   localparam logic [COUNT_WIDTH-1:0] COUNT_RESET = 8'h00;
   localparam int POST_SEL_WIDTH = 4;
   localparam int POST_WIDTH = 16;
   localparam logic [POST_WIDTH-1:0] POST_RESET = 16'h0000;
   localparam logic [POST_WIDTH-1:0] POST_ONE = 16'h0001;
   localparam int ELAPSED_WIDTH = COUNT_WIDTH + POST_WIDTH;
   // three quarters of one postscaler unit (256 counter ticks)
   localparam logic [ELAPSED_WIDTH-1:0] WINDOW_BASE = 24'h0000c0;

   // =====================================================================
   // power-save modes
   typedef enum logic [1:0] {
      PWR_RUN,
      PWR_SLEEP,
      PWR_IDLE
   } pwr_mode_t;

endpackage

/* File: rtl/wdt_prescaler.sv */
/*
 Prescaler stage of the watchdog: divides the clock into counter ticks.
 Assumes the parent drives clear and enable synchronously to mclk_i.
*/
`timescale 1ns/10ps
module wdt_prescaler (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // control
   input wire logic clear_i,
   input wire logic enable_i,
   // tick out
   output logic tick_o
);

   // =====================================================================
   // state
   typedef struct packed {
      logic [wdt_pkg::PRESCALE_WIDTH-1:0] count;
   } presc_state_t;

   presc_state_t s;
   presc_state_t next_s;

   // tick depends on state and enable_i only, so parent clears cannot loop back
   assign tick_o = enable_i && (s.count == wdt_pkg::PRESCALE_LAST);

   always_comb begin
      next_s = s;
      if (clear_i) begin
         next_s.count = wdt_pkg::PRESCALE_RESET;
      end else if (enable_i) begin
         if (s.count == wdt_pkg::PRESCALE_LAST) begin
            next_s.count = wdt_pkg::PRESCALE_RESET;
         end else begin
            next_s.count = s.count + 1'b1;
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         s.count <= wdt_pkg::PRESCALE_RESET;
      end else begin
         s <= next_s;
      end
   end

endmodule

/* File: rtl/watchdog_timer_control.sv */
/*
 Watchdog timer with prescaler, counter and postscaler, power-save mode
 tracking, fixed-window clear checking and the three enable schemes.
 Assumes the processor core pulses the instruction inputs for one cycle,
 and that the reset output is routed back as device_reset_i by the
 reset controller. rst_i is the power-on reset of the whole block.
*/
// Function
// - any device reset clears counter, prescaler and postscaler
// - completed clock switch, software or fail-safe, clears all counts
// - power-save instruction entering sleep or idle clears all counts
// - leaving sleep or idle back to run clears all counts
// - clear instruction in normal run clears counter and both scalers
// - enable field 11 keeps the watchdog counting in sleep and idle
// - time-out in sleep or idle wakes the core without a reset
// - time-out flag is sticky until software clears it
// - windowed mode: clear restarts the count, without a reset only in the last quarter
// - windowed mode: an early clear causes a watchdog reset
// - windowed mode is active when the window-disable bit is 0
// - enable field 11 makes the watchdog permanently enabled
// - enable field 10 runs the watchdog only while software enable set
// - software enable bit returns to zero on every device reset
// - enable field 01 runs in run and idle, stops in sleep
// - enable field 01 ignores the software enable bit
`timescale 1ns/10ps
module watchdog_timer_control (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic device_reset_i,
   // configuration word
   input wire logic [1:0] watchdog_enable_config_i,
   input wire logic window_disable_config_i,
   input wire logic [3:0] postscale_select_i,
   // core instructions
   input wire logic watchdog_clear_instruction_i,
   input wire logic power_save_instruction_i,
   input wire logic power_save_idle_i,
   input wire logic wake_event_i,
   // clock switch
   input wire logic clock_switch_done_i,
   // reset-control register accesses
   input wire logic software_watchdog_enable_wr_i,
   input wire logic software_watchdog_enable_data_i,
   input wire logic timeout_flag_clear_i,
   input wire logic sleep_status_clear_i,
   input wire logic idle_status_clear_i,
   // reset-control register state
   output logic software_watchdog_enable_o,
   output logic watchdog_timeout_flag_o,
   output logic sleep_status_o,
   output logic idle_status_o,
   // events and observation
   output logic watchdog_reset_o,
   output logic wake_o,
   output logic sleeping_o,
   output logic idling_o,
   output logic running_o,
   output logic [7:0] count_o
);

   // =====================================================================
   // state
   typedef struct packed {
      wdt_pkg::pwr_mode_t mode;
      logic [wdt_pkg::COUNT_WIDTH-1:0] count;
      logic [wdt_pkg::POST_WIDTH-1:0] post;
      logic flag;
      logic swen;
      logic sleep_st;
      logic idle_st;
      logic wdt_reset;
      logic wake;
   } wdt_state_t;

   wdt_state_t s;
   wdt_state_t next_s;
   logic clear_counts;
   logic run;
   logic tick;

   // =====================================================================
   // decoding helpers
   function automatic logic wdt_enabled(
      input logic [1:0] cfg,
      input logic swen,
      input wdt_pkg::pwr_mode_t mode
   );
      logic en;
      en = 1'b0;
      if (cfg == wdt_pkg::CFG_ALWAYS) begin
         en = 1'b1;
      end else if (cfg == wdt_pkg::CFG_SOFTWARE) begin
         en = swen;
      end else if (cfg == wdt_pkg::CFG_RUN_IDLE) begin
         en = (mode != wdt_pkg::PWR_SLEEP);
      end else begin
         en = 1'b0;
      end
      return en;
   endfunction

   // elapsed time against three quarters of the programmed period
   function automatic logic window_open(
      input logic [wdt_pkg::POST_WIDTH-1:0] post,
      input logic [wdt_pkg::COUNT_WIDTH-1:0] count,
      input logic [3:0] sel
   );
      logic [wdt_pkg::ELAPSED_WIDTH-1:0] elapsed;
      logic [wdt_pkg::ELAPSED_WIDTH-1:0] limit;
      elapsed = {post, count};
      limit = wdt_pkg::WINDOW_BASE << sel;
      return elapsed >= limit;
   endfunction

   function automatic logic [wdt_pkg::POST_WIDTH-1:0] post_last(
      input logic [3:0] sel
   );
      logic [wdt_pkg::POST_WIDTH-1:0] ratio;
      ratio = wdt_pkg::POST_ONE << sel;
      return ratio - wdt_pkg::POST_ONE;
   endfunction

   // =====================================================================
   // prescaler stage
   assign run = wdt_enabled(watchdog_enable_config_i, s.swen, s.mode);

   wdt_prescaler u_prescaler (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .clear_i(clear_counts),
      .enable_i(run),
      .tick_o(tick)
   );

   // =====================================================================
   // next-state logic
   always_comb begin
      logic timeout;
      logic early_clear;
      timeout = 1'b0;
      early_clear = 1'b0;
      clear_counts = 1'b0;
      next_s = s;
      next_s.wdt_reset = 1'b0;
      next_s.wake = 1'b0;

      // counter and postscaler advance
      if (run && tick) begin
         if (s.count == wdt_pkg::COUNT_LAST) begin
            next_s.count = wdt_pkg::COUNT_RESET;
            if (s.post == post_last(postscale_select_i)) begin
               next_s.post = wdt_pkg::POST_RESET;
               timeout = 1'b1;
            end else begin
               next_s.post = s.post + wdt_pkg::POST_ONE;
            end
         end else begin
            next_s.count = s.count + 1'b1;
         end
      end

      // software clears first, so a same-cycle set wins
      if (timeout_flag_clear_i) begin
         next_s.flag = 1'b0;
      end
      if (sleep_status_clear_i) begin
         next_s.sleep_st = 1'b0;
      end
      if (idle_status_clear_i) begin
         next_s.idle_st = 1'b0;
      end
      if (software_watchdog_enable_wr_i) begin
         // stored in every mode; only the 10 setting looks at it
         next_s.swen = software_watchdog_enable_data_i;
      end

      // clock switch completion
      if (clock_switch_done_i) begin
         clear_counts = 1'b1;
      end

      if (s.mode == wdt_pkg::PWR_RUN) begin
         if (timeout) begin
            next_s.flag = 1'b1;
            next_s.wdt_reset = 1'b1;
            clear_counts = 1'b1;
         end else if (watchdog_clear_instruction_i) begin
            // an early clear in windowed mode behaves like a time-out
            early_clear = !window_disable_config_i && run &&
               !window_open(s.post, s.count, postscale_select_i);
            if (early_clear) begin
               next_s.flag = 1'b1;
               next_s.wdt_reset = 1'b1;
            end
            clear_counts = 1'b1;
         end else if (power_save_instruction_i) begin
            if (power_save_idle_i) begin
               next_s.mode = wdt_pkg::PWR_IDLE;
               next_s.idle_st = 1'b1;
            end else begin
               next_s.mode = wdt_pkg::PWR_SLEEP;
               next_s.sleep_st = 1'b1;
            end
            clear_counts = 1'b1;
         end
      end else begin
         if (timeout) begin
            // wake in place; status bits stay for software to clear
            next_s.flag = 1'b1;
            next_s.wake = 1'b1;
            next_s.mode = wdt_pkg::PWR_RUN;
            clear_counts = 1'b1;
         end else if (wake_event_i) begin
            next_s.wake = 1'b1;
            next_s.mode = wdt_pkg::PWR_RUN;
            clear_counts = 1'b1;
         end
      end

      // any other device reset, including our own routed back
      if (device_reset_i) begin
         clear_counts = 1'b1;
         next_s.swen = 1'b0;
         next_s.mode = wdt_pkg::PWR_RUN;
         next_s.wake = 1'b0;
      end

      if (clear_counts) begin
         next_s.count = wdt_pkg::COUNT_RESET;
         next_s.post = wdt_pkg::POST_RESET;
      end
   end

   // =====================================================================
   // state register; the flag survives device_reset_i on purpose
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         s.mode <= wdt_pkg::PWR_RUN;
         s.count <= wdt_pkg::COUNT_RESET;
         s.post <= wdt_pkg::POST_RESET;
         s.flag <= 1'b0;
         s.swen <= 1'b0;
         s.sleep_st <= 1'b0;
         s.idle_st <= 1'b0;
         s.wdt_reset <= 1'b0;
         s.wake <= 1'b0;
      end else begin
         s <= next_s;
      end
   end

   // =====================================================================
   // outputs
   assign software_watchdog_enable_o = s.swen;
   assign watchdog_timeout_flag_o = s.flag;
   assign sleep_status_o = s.sleep_st;
   assign idle_status_o = s.idle_st;
   assign watchdog_reset_o = s.wdt_reset;
   assign wake_o = s.wake;
   assign sleeping_o = (s.mode == wdt_pkg::PWR_SLEEP);
   assign idling_o = (s.mode == wdt_pkg::PWR_IDLE);
   assign running_o = run;
   assign count_o = s.count;

endmodule

/* File: test/wdt_asserts.sv */
/*
 Port-level checks for the watchdog block.
 Assumes sel 0 during windowed clears, so count_o is the whole elapsed time.
*/
`timescale 1ns/10ps
module wdt_asserts (
   // watched inputs
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic device_reset_i,
   input wire logic [1:0] watchdog_enable_config_i,
   input wire logic window_disable_config_i,
   input wire logic [3:0] postscale_select_i,
   input wire logic watchdog_clear_instruction_i,
   input wire logic clock_switch_done_i,
   input wire logic timeout_flag_clear_i,
   // watched outputs
   input wire logic software_watchdog_enable_o,
   input wire logic watchdog_timeout_flag_o,
   input wire logic watchdog_reset_o,
   input wire logic wake_o,
   input wire logic sleeping_o,
   input wire logic idling_o,
   input wire logic running_o,
   input wire logic [7:0] count_o
);
   // ==========================================================
   // assertions
   default clocking @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   wire run_mode = running_o && !sleeping_o && !idling_o;
   a_devrst_count: assert property (device_reset_i |=> count_o == 8'h00) else $error("count kept over reset");
   a_switch_count: assert property (clock_switch_done_i |=> count_o == 8'h00) else $error("count kept over switch");
   a_clear_count: assert property (watchdog_clear_instruction_i && run_mode |=> count_o == 8'h00)
      else $error("clear left count");
   a_flag_sticky: assert property (watchdog_timeout_flag_o && !timeout_flag_clear_i |=> watchdog_timeout_flag_o)
      else $error("flag dropped");
   a_early_window: assert property (!window_disable_config_i && postscale_select_i == 4'h0 && run_mode
      && watchdog_clear_instruction_i && !device_reset_i && count_o < 8'hc0 |=> watchdog_reset_o)
      else $error("early clear not punished");
   a_always_on: assert property (watchdog_enable_config_i == 2'h3 |-> running_o) else $error("not running");
   a_soft_run: assert property (watchdog_enable_config_i == 2'h2 |-> running_o == software_watchdog_enable_o)
      else $error("swen mismatch");
   a_swen_reset: assert property (device_reset_i |=> !software_watchdog_enable_o) else $error("swen kept");
   a_reset_flag: assert property ($rose(watchdog_reset_o) |-> watchdog_timeout_flag_o) else $error("no flag");
   a_off_stopped: assert property (watchdog_enable_config_i == 2'h0 |-> !running_o) else $error("off runs");
   c_reset: cover property (watchdog_reset_o);
   c_wake: cover property (wake_o);
   c_window: cover property (!window_disable_config_i && watchdog_clear_instruction_i && count_o >= 8'hc0);
endmodule
bind watchdog_timer_control wdt_asserts wdt_asserts_inst (.*);

/* File: test/core_model.sv */
/*
 Processor core side: routes watchdog resets back, clears status after wake.
 Assumes mclk_i is the device clock.
*/
`timescale 1ns/10ps
module core_model (
   // clock
   input wire logic mclk_i,
   // requests
   input wire logic reset_req_i,
   input wire logic watchdog_reset_i,
   input wire logic wake_i,
   // to the block
   output logic device_reset_o = 1'b0,
   output logic status_clear_o = 1'b0
);
   always_ff @(posedge mclk_i) begin
      device_reset_o <= watchdog_reset_i | reset_req_i;
      // software clears its own sleep and idle status after waking
      status_clear_o <= wake_i;
   end
endmodule

/* File: test/tb.sv */
/*
 Self-checking bench for the watchdog block.
 Assumes the core model returns resets and clears status after wake.
*/
`timescale 1ns/10ps
module tb;
   // ==========================================================
   // signals
   localparam int CLR = 0, PS = 1, WAKE = 2, SWITCH = 3, FCLR = 4, SWWR = 5, RQ = 6;
   logic mclk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [1:0] watchdog_enable_config_i = 2'h0;
   logic window_disable_config_i = 1'b1;
   logic [3:0] postscale_select_i = 4'h0;
   logic power_save_idle_i = 1'b0;
   logic software_watchdog_enable_data_i = 1'b0;
   logic [6:0] pl = 7'h00;
   wire logic watchdog_clear_instruction_i, power_save_instruction_i, wake_event_i, clock_switch_done_i;
   wire logic timeout_flag_clear_i, software_watchdog_enable_wr_i, reset_req;
   wire logic device_reset_i, sleep_status_clear_i, idle_status_clear_i;
   logic software_watchdog_enable_o, watchdog_timeout_flag_o, sleep_status_o, idle_status_o;
   logic watchdog_reset_o, wake_o, sleeping_o, idling_o, running_o, hit;
   logic [7:0] count_o;
   int error_cnt = 0;
   int checked = 0;
   int cycles = 0;
   assign {reset_req, software_watchdog_enable_wr_i, timeout_flag_clear_i, clock_switch_done_i, wake_event_i,
      power_save_instruction_i, watchdog_clear_instruction_i} = pl;
   assign idle_status_clear_i = sleep_status_clear_i;
   watchdog_timer_control watchdog_timer_control_inst (.*);
   core_model core_model_inst (.mclk_i(mclk_i), .reset_req_i(reset_req), .watchdog_reset_i(watchdog_reset_o),
      .wake_i(wake_o), .device_reset_o(device_reset_i), .status_clear_o(sleep_status_clear_i));
   always #2 mclk_i = ~mclk_i;
   always @(posedge mclk_i) begin
      cycles++;
      if (cycles == 40000) begin
         error_cnt++;
         wrap_up();
      end
   end
   // ==========================================================
   // tasks
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge mclk_i);
      #1;
   endtask
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checked++;
      if (got !== exp) begin
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
         error_cnt++;
      end
   endtask
   // one-cycle instruction or register strobe
   task automatic pulse(input int k);
      pl = 7'h01 << k;
      step(1);
      pl = 7'h00;
   endtask
   task automatic wait_hi(input logic use_wake, input int lim);
      hit = 1'b0;
      for (int i = 0; i < lim && hit !== 1'b1; i++) begin
         step(1);
         hit = use_wake ? wake_o : watchdog_reset_o;
      end
   endtask
   // ==========================================================
   // tests
   initial begin
      step(3);
      rst_i = 1'b0;
      step(101);
      chk("off", 8'h00, {running_o, count_o[6:0]});
      chk("swen", 8'h00, software_watchdog_enable_o);
      $display("test off done");
      watchdog_enable_config_i = 2'h3;
      step(100);
      chk("moving", 8'h01, running_o && count_o != 8'h00);
      pulse(CLR);
      chk("clear", 8'h00, count_o | watchdog_reset_o);
      step(100);
      pulse(SWITCH);
      chk("switch", 8'h00, count_o);
      wait_hi(1'b0, 9000);
      chk("timeout", 8'h01, hit & watchdog_timeout_flag_o);
      step(3);
      chk("after rst", 8'h01, {count_o[6:0], watchdog_timeout_flag_o});
      pulse(FCLR);
      chk("flag clr", 8'h00, watchdog_timeout_flag_o);
      $display("test run done");
      pulse(PS);
      chk("sleep", 8'h03, {sleeping_o & sleep_status_o, count_o == 8'h00});
      step(100);
      chk("sleep cnt", 8'h01, count_o != 8'h00);
      wait_hi(1'b1, 9000);
      chk("wake", 8'h03, {hit & !watchdog_reset_o & !sleeping_o, watchdog_timeout_flag_o});
      chk("wake cnt", 8'h00, count_o);
      step(2);
      chk("status", 8'h00, sleep_status_o);
      pulse(FCLR);
      $display("test sleep done");
      watchdog_enable_config_i = 2'h1;
      pulse(PS);
      step(100);
      chk("halted", 8'h00, {running_o, count_o[6:0]});
      pulse(WAKE);
      chk("exit", 8'h01, wake_o & running_o);
      pulse(SWWR);
      chk("swen ign", 8'h01, running_o);
      power_save_idle_i = 1'b1;
      pulse(PS);
      power_save_idle_i = 1'b0;
      step(100);
      chk("idle", 8'h01, idling_o & idle_status_o & (count_o != 8'h00));
      pulse(WAKE);
      chk("idle exit", 8'h00, count_o);
      $display("test run_idle done");
      watchdog_enable_config_i = 2'h2;
      step(1);
      chk("sw off", 8'h00, running_o);
      software_watchdog_enable_data_i = 1'b1;
      pulse(SWWR);
      software_watchdog_enable_data_i = 1'b0;
      chk("sw on", 8'h01, running_o);
      pulse(RQ);
      step(1);
      chk("swen rst", 8'h00, software_watchdog_enable_o);
      $display("test software done");
      watchdog_enable_config_i = 2'h3;
      window_disable_config_i = 1'b0;
      step(40);
      pulse(CLR);
      chk("early", 8'h01, watchdog_reset_o);
      step(3);
      for (int i = 0; i < 7000 && count_o !== 8'hc0; i++) step(1);
      pulse(CLR);
      chk("window", 8'h00, count_o | watchdog_reset_o);
      $display("test window done");
      wrap_up();
   end
endmodule
